// ### rtl/asi_map.vh
// Purpose: register offsets, field positions, reset values and timing counts of the serial transceiver pair
// Assumes: 32-bit bus word per register, byte address bits [1:0] ignored
// Notes: definitions only
`ifndef ASI_MAP_VH
`define ASI_MAP_VH

// byte address layout: bit 5 picks the channel, bits 4:2 pick the register
`define ASI_CH_BIT 5
`define ASI_REG_HI 4
`define ASI_REG_LO 2

// register indices inside one channel block
`define ASI_REG_BDH 3'h0
`define ASI_REG_BDL 3'h1
`define ASI_REG_CR1 3'h2
`define ASI_REG_CR2 3'h3
`define ASI_REG_SR1 3'h4
`define ASI_REG_SR2 3'h5
`define ASI_REG_DRH 3'h6
`define ASI_REG_DRL 3'h7

// frame_and_loop_control fields
`define ASI_CR1_ODD 0
`define ASI_CR1_PAR_ON 1
`define ASI_CR1_M 4
`define ASI_CR1_RX_SEL 5
`define ASI_CR1_OPEN_DRAIN 6
`define ASI_CR1_FEEDBACK 7

// second control register fields
`define ASI_CR2_BREAK 0
`define ASI_CR2_RX_ON 2
`define ASI_CR2_TX_ON 3
`define ASI_CR2_RX_WAKE 5

// status fields
`define ASI_SR1_PAR_ERR 0
`define ASI_SR1_FRM_ERR 1
`define ASI_SR1_OVR 3
`define ASI_SR1_FULL 5
`define ASI_SR1_DONE 6
`define ASI_SR1_EMPTY 7
`define ASI_SR1_RX_MASK 8'h3F
`define ASI_SR1_TX_MASK 8'hC0

// reset values
`define ASI_CR_RST 8'h00
`define ASI_BD_RST 16'h0000
`define ASI_DIV_RST 13'h0000

// oversampling: sixteen ticks per bit, centre sample on tick 7
`define ASI_SUB_LAST 4'hF
`define ASI_SUB_MID 4'h7
`define ASI_BITS_8 4'h9
`define ASI_BITS_9 4'hA

`endif

// ### rtl/asi_top.v
// Purpose: two independent asynchronous NRZ serial transceivers behind an Avalon-MM slave
// Assumes: mclk 200 MHz, ce freezes all state, pin inputs and supply level are asynchronous
// Notes: one wait state per bus access; pin output enables are active low
`include "asi_map.vh"
`default_nettype none

module asi_top (
   // clock, freeze and reset
   input wire mclk,
   input wire ce,
   input wire rst_n,
   // avalon-mm slave
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // system mode
   input wire special_mode,
   input wire wait_mode,
   input wire clock_synth_supply,
   // port logic, one bit per channel
   input wire [1:0] tx_pin_direction_bit,
   input wire [1:0] rx_pin_direction_bit,
   input wire [1:0] gpio_tx_out,
   input wire [1:0] gpio_rx_out,
   // serial pins, one bit per channel
   input wire [1:0] pin_tx_in,
   output reg [1:0] pin_tx_out,
   output reg [1:0] pin_tx_oe_n,
   input wire [1:0] pin_rx_in,
   output reg [1:0] pin_rx_out,
   output reg [1:0] pin_rx_oe_n,
   // receiver wake request, one bit per channel
   output reg [1:0] rx_wake_irq
);

   localparam TX_IDLE = 2'b01;
   localparam TX_SEND = 2'b10;
   localparam RX_HUNT = 2'b01;
   localparam RX_RECV = 2'b10;

   // pin drive: {out, oe_n}; open drain only ever pulls low
   function [1:0] pin_drive(input v, input en, input od);
      begin
         pin_drive = {v, ~(en & (~od | ~v))};
      end
   endfunction

   // parity over the bits below the parity position
   function par_of(input [8:0] d, input m, input odd);
      begin
         par_of = (m ? ^d[7:0] : ^d[6:0]) ^ odd;
      end
   endfunction

   wire req = avs_read | avs_write;
   wire acc = req & ~avs_waitrequest;
   wire [15:0] chan_rd;
   wire [3:0] next_tx_pin;
   wire [3:0] next_rx_pin;
   wire [1:0] next_wake;
   reg [1:0] tx_s1, tx_s2, rx_s1, rx_s2;
   reg sup_s1, sup_s2;

   // bus handshake: waitrequest drops for exactly one cycle per request
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (ce) begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            avs_readdata <= {24'h000000, (avs_address[`ASI_CH_BIT] ? chan_rd[15:8] : chan_rd[7:0])};
         end
      end
   end

   // two-flop synchronisers, then registered pin drive
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_s1 <= 2'h3;
         tx_s2 <= 2'h3;
         rx_s1 <= 2'h3;
         rx_s2 <= 2'h3;
         sup_s1 <= 1'b0;
         sup_s2 <= 1'b0;
         pin_tx_out <= 2'h3;
         pin_tx_oe_n <= 2'h3;
         pin_rx_out <= 2'h3;
         pin_rx_oe_n <= 2'h3;
         rx_wake_irq <= 2'h0;
      end else if (ce) begin
         tx_s1 <= pin_tx_in;
         tx_s2 <= tx_s1;
         rx_s1 <= pin_rx_in;
         rx_s2 <= rx_s1;
         sup_s1 <= clock_synth_supply;
         sup_s2 <= sup_s1;
         pin_tx_out <= {next_tx_pin[3], next_tx_pin[1]};
         pin_tx_oe_n <= {next_tx_pin[2], next_tx_pin[0]};
         pin_rx_out <= {next_rx_pin[3], next_rx_pin[1]};
         pin_rx_oe_n <= {next_rx_pin[2], next_rx_pin[0]};
         rx_wake_irq <= next_wake;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : chan
         wire sel = (avs_address[`ASI_CH_BIT] == (gi != 0));
         wire [2:0] ri = avs_address[`ASI_REG_HI:`ASI_REG_LO];
         wire wr = acc & avs_write & avs_byteenable[0] & sel;
         wire rd = acc & avs_read & sel;
         wire [7:0] wd = avs_writedata[7:0];
         reg [7:0] frame_and_loop_control;
         reg [7:0] ctl2;
         reg [7:0] bd_stage;
         reg [15:0] baud_divisor_pair;
         reg [12:0] bd_cnt;
         reg bd_on;
         reg [8:0] tx_buf, rx_dr;
         reg [7:0] snap;
         reg tdre, tc, rdrf, ovr_flag, fe, pf;
         reg [1:0] tx_state, rx_state;
         reg [10:0] tx_sh;
         reg [9:0] rx_sh;
         reg [3:0] tx_sub, tx_bits, rx_sub, rx_bits;
         reg tx_line;
         reg [7:0] rd_val;
         reg [1:0] tx_pin_v, rx_pin_v;

         wire internal_feedback_select = frame_and_loop_control[`ASI_CR1_FEEDBACK];
         wire rx_input_select = frame_and_loop_control[`ASI_CR1_RX_SEL];
         wire open_drain_select = frame_and_loop_control[`ASI_CR1_OPEN_DRAIN];
         wire len9 = frame_and_loop_control[`ASI_CR1_M];
         wire parity_on = frame_and_loop_control[`ASI_CR1_PAR_ON];
         wire parity_odd_select = frame_and_loop_control[`ASI_CR1_ODD];
         wire tx_side_on = ctl2[`ASI_CR2_TX_ON];
         wire rx_side_on = ctl2[`ASI_CR2_RX_ON];
         wire send_break = ctl2[`ASI_CR2_BREAK];
         wire rx_busy_flag = rx_state[1];
         wire [12:0] baud_divisor_field = baud_divisor_pair[12:0];
         wire [3:0] last_bit = len9 ? `ASI_BITS_9 : `ASI_BITS_8;

         // sixteen ticks per bit; silent until first enable or while divisor is zero
         wire tick = bd_on & (baud_divisor_field != `ASI_DIV_RST) &
                     (bd_cnt == baud_divisor_field - 13'h0001);

         // transmit frame: start low, data lsb first, optional parity in last data slot, stop high
         wire [8:0] tx_dat = parity_on ?
            (len9 ? {par_of(tx_buf, 1'b1, parity_odd_select), tx_buf[7:0]} :
                    {1'b0, par_of(tx_buf, 1'b0, parity_odd_select), tx_buf[6:0]}) : tx_buf;
         wire [10:0] tx_frame = len9 ? {1'b1, tx_dat, 1'b0} : {2'h3, tx_dat[7:0], 1'b0};
         wire tx_load = tick & tx_state[0] & tx_side_on & ~send_break & ~tdre;

         // receive source: pin, internal transmit line or transmit pin
         wire rx_src = internal_feedback_select ? (rx_input_select ? tx_s2[gi] : tx_line) : rx_s2[gi];
         wire rx_mid = tick & rx_state[1] & (rx_sub == `ASI_SUB_MID);
         // the frame ends at the centre of the stop bit, so framing is judged on the stop level
         wire rx_done = rx_mid & (rx_bits == last_bit);
         wire [9:0] rx_full = {rx_src, rx_sh[9:1]};
         wire [8:0] rx_dat = len9 ? rx_full[8:0] : {1'b0, rx_full[8:1]};
         wire rx_pbit = len9 ? rx_dat[8] : rx_dat[7];

         // flag events; a set in the clearing cycle wins
         wire set_full = rx_done & ~rdrf;
         wire set_ovr = rx_done & rdrf;
         wire set_fe = set_full & ~rx_src;
         wire set_pf = set_full & parity_on & (par_of(rx_dat, len9, parity_odd_select) != rx_pbit);
         wire [7:0] clr_rx = (rd & (ri == `ASI_REG_DRL)) ? (snap & `ASI_SR1_RX_MASK) : 8'h00;
         wire [7:0] clr_tx = (wr & (ri == `ASI_REG_DRL)) ? (snap & `ASI_SR1_TX_MASK) : 8'h00;
         wire set_tc = tx_state[0] & tdre & ~send_break & ~tx_load;
         wire [7:0] sr1 = {tdre, tc, rdrf, 1'b0, ovr_flag, 1'b0, fe, pf};

         // register read mux, decoded from the word index
         always @* begin
            if (ri == `ASI_REG_BDH) begin
               rd_val = bd_stage;
            end else if (ri == `ASI_REG_BDL) begin
               rd_val = baud_divisor_pair[7:0];
            end else if (ri == `ASI_REG_CR1) begin
               rd_val = frame_and_loop_control;
            end else if (ri == `ASI_REG_CR2) begin
               rd_val = ctl2;
            end else if (ri == `ASI_REG_SR1) begin
               rd_val = sr1;
            end else if (ri == `ASI_REG_SR2) begin
               rd_val = {7'h00, rx_busy_flag};
            end else if (ri == `ASI_REG_DRH) begin
               rd_val = {rx_dr[8], tx_buf[8], 6'h00};
            end else begin
               rd_val = rx_dr[7:0];
            end
         end
         assign chan_rd[gi * 8 + 7:gi * 8] = rd_val;

         // software registers and the status flag set
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               frame_and_loop_control <= `ASI_CR_RST;
               ctl2 <= `ASI_CR_RST;
               bd_stage <= `ASI_CR_RST;
               baud_divisor_pair <= `ASI_BD_RST;
               bd_on <= 1'b0;
               tx_buf <= 9'h000;
               snap <= 8'h00;
               tdre <= 1'b1;
               tc <= 1'b1;
               rdrf <= 1'b0;
               ovr_flag <= 1'b0;
               fe <= 1'b0;
               pf <= 1'b0;
            end else if (ce) begin
               if (wr & (ri == `ASI_REG_BDH)) begin
                  bd_stage[4:0] <= wd[4:0];
                  if (special_mode) begin
                     bd_stage[7:5] <= wd[7:5];
                  end
               end
               if (wr & (ri == `ASI_REG_BDL)) begin
                  baud_divisor_pair <= {bd_stage, wd};
               end
               if (wr & (ri == `ASI_REG_CR1)) begin
                  frame_and_loop_control <= wd;
               end
               if (wr & (ri == `ASI_REG_CR2)) begin
                  ctl2 <= wd;
                  if (wd[`ASI_CR2_TX_ON] | wd[`ASI_CR2_RX_ON]) begin
                     bd_on <= 1'b1;
                  end
               end
               if (wr & (ri == `ASI_REG_DRH)) begin
                  tx_buf[8] <= wd[6];
               end
               if (wr & (ri == `ASI_REG_DRL)) begin
                  tx_buf[7:0] <= wd;
               end
               // the status read arms the clear; the data access consumes it
               if (rd & (ri == `ASI_REG_SR1)) begin
                  snap <= sr1;
               end else if (|clr_rx | |clr_tx) begin
                  snap <= 8'h00;
               end
               tdre <= tx_load | (tdre & ~clr_tx[`ASI_SR1_EMPTY]);
               tc <= set_tc | (tc & ~clr_tx[`ASI_SR1_DONE]);
               rdrf <= set_full | (rdrf & ~clr_rx[`ASI_SR1_FULL]);
               ovr_flag <= set_ovr | (ovr_flag & ~clr_rx[`ASI_SR1_OVR]);
               fe <= set_fe | (fe & ~clr_rx[`ASI_SR1_FRM_ERR]);
               pf <= set_pf | (pf & ~clr_rx[`ASI_SR1_PAR_ERR]);
            end
         end

         // baud modulus counter, restarts on each tick
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               bd_cnt <= `ASI_DIV_RST;
            end else if (ce) begin
               if (tick | ~bd_on | (baud_divisor_field == `ASI_DIV_RST)) begin
                  bd_cnt <= `ASI_DIV_RST;
               end else begin
                  bd_cnt <= bd_cnt + 13'h0001;
               end
            end
         end

         // transmitter: a frame in flight finishes on tx_line, though in normal mode the pin drops it once tx_side_on clears; break repeats all-zero frames
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               tx_state <= TX_IDLE;
               tx_sh <= 11'h7FF;
               tx_sub <= 4'h0;
               tx_bits <= 4'h0;
               tx_line <= 1'b1;
            end else if (ce & tick) begin
               case (tx_state)
                  TX_IDLE: begin
                     tx_line <= 1'b1;
                     if (tx_side_on & (send_break | ~tdre)) begin
                        tx_sh <= send_break ? 11'h000 : tx_frame;
                        tx_line <= 1'b0;
                        tx_sub <= 4'h0;
                        tx_bits <= 4'h0;
                        tx_state <= TX_SEND;
                     end
                  end
                  TX_SEND: begin
                     tx_sub <= tx_sub + 4'h1;
                     if (tx_sub == `ASI_SUB_LAST) begin
                        if (tx_bits == last_bit) begin
                           // a held break runs straight into the next all-zero frame, no mark gap
                           tx_line <= ~send_break;
                           tx_state <= TX_IDLE;
                        end else begin
                           tx_sh <= {1'b1, tx_sh[10:1]};
                           tx_line <= tx_sh[1];
                           tx_bits <= tx_bits + 4'h1;
                        end
                     end
                  end
                  default: begin
                     tx_state <= TX_IDLE;
                  end
               endcase
            end
         end

         // receiver: start confirmed at its centre, then one sample per sixteen ticks
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               rx_state <= RX_HUNT;
               rx_sh <= 10'h000;
               rx_sub <= 4'h0;
               rx_bits <= 4'h0;
               rx_dr <= 9'h000;
            end else if (ce & tick) begin
               case (rx_state)
                  RX_HUNT: begin
                     if (rx_side_on & ~rx_src) begin
                        rx_sub <= 4'h0;
                        rx_bits <= 4'h0;
                        rx_state <= RX_RECV;
                     end
                  end
                  RX_RECV: begin
                     rx_sub <= rx_sub + 4'h1;
                     if (rx_sub == `ASI_SUB_LAST) begin
                        rx_bits <= rx_bits + 4'h1;
                     end
                     if (rx_sub == `ASI_SUB_MID) begin
                        if ((rx_bits == 4'h0) & rx_src) begin
                           rx_state <= RX_HUNT; // glitch, not a start bit
                        end else if (rx_done) begin
                           rx_state <= RX_HUNT;
                           if (~rdrf) begin
                              rx_dr <= rx_dat;
                           end
                        end else if (rx_bits != 4'h0) begin
                           rx_sh <= rx_full;
                        end
                     end
                  end
                  default: begin
                     rx_state <= RX_HUNT;
                  end
               endcase
            end
         end

         // pin functions; the general purpose fallback still honours open drain
         always @* begin
            if (internal_feedback_select) begin
               if (tx_pin_direction_bit[gi]) begin
                  tx_pin_v = pin_drive(tx_line, 1'b1, open_drain_select);
               end else begin
                  tx_pin_v = pin_drive(1'b1, ~rx_input_select, open_drain_select);
               end
            end else if (tx_side_on) begin
               tx_pin_v = pin_drive(tx_line, 1'b1, open_drain_select);
            end else begin
               tx_pin_v = pin_drive(gpio_tx_out[gi], tx_pin_direction_bit[gi], open_drain_select);
            end
            if (internal_feedback_select | ~rx_side_on) begin
               rx_pin_v = pin_drive(gpio_rx_out[gi], rx_pin_direction_bit[gi], open_drain_select);
            end else begin
               rx_pin_v = 2'h1;
            end
         end
         assign next_tx_pin[gi * 2 + 1:gi * 2] = tx_pin_v;
         assign next_rx_pin[gi * 2 + 1:gi * 2] = rx_pin_v;
         assign next_wake[gi] = ctl2[`ASI_CR2_RX_WAKE] & rx_busy_flag & wait_mode & sup_s2;
      end
   endgenerate

endmodule

`default_nettype wire

// ### tb/asi_checker.sv
// Purpose: port-level checks on the serial transceiver pair
// Assumes: single clock domain, ce held high by the bench
// Notes: bound to the top module, sees only its ports
`default_nettype none
module asi_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // mode and pins
   input wire logic wait_mode,
   input wire logic clock_synth_supply,
   input wire logic [1:0] rx_pin_direction_bit,
   input wire logic [1:0] pin_rx_oe_n,
   input wire logic [1:0] rx_wake_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // bus handshake: one wait state, one-cycle answer
   a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_answer_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_answer_has_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_rdata_byte_wide: assert property (avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_rdata_holds: assert property (!$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
      else $error("read data changed without read");
   // wake request only in wait with supply present
   a_wake_in_wait: assert property ((|rx_wake_irq) |-> $past(wait_mode))
      else $error("wake request outside wait");
   a_wake_no_supply: assert property (!clock_synth_supply [*4] |=> rx_wake_irq == 2'b00)
      else $error("wake request with supply at ground");
   // receive pin never driven while it is an input
   a_rx_pin_quiet: assert property (rx_pin_direction_bit == 2'b00 |=> pin_rx_oe_n == 2'b11)
      else $error("receive pin driven as input");
endmodule
bind asi_top asi_checker i_chk (.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wait_mode(wait_mode),
   .clock_synth_supply(clock_synth_supply), .rx_pin_direction_bit(rx_pin_direction_bit),
   .pin_rx_oe_n(pin_rx_oe_n), .rx_wake_irq(rx_wake_irq));
`default_nettype wire

// ### tb/asi_remote.sv
// Purpose: far-end asynchronous transceiver on the serial line
// Assumes: bit time given in mclk cycles
// Notes: line sampled mid-cycle so registered pin changes never race
`default_nettype none
module asi_remote (
   // clock
   input wire logic mclk,
   // line from and to the device
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int bit_cycles = 16;
   initial line_out = 1'b1; // mark when idle
   // send n bits, start first, then back to mark
   task automatic send(input logic [10:0] fr, input int n);
      for (int i = 0; i < n; i++) begin
         line_out <= fr[i];
         repeat (bit_cycles) @(posedge mclk);
      end
      line_out <= 1'b1;
   endtask
   // hold the line at one level
   task automatic hold(input logic v);
      line_out <= v;
   endtask
   // wait for a start edge, then take n bit centres
   task automatic catch_frame(input int n, output logic [10:0] fr);
      int w;
      fr = 11'h7FF;
      w = 0;
      while (line_in !== 1'b0 && w < 3000) begin
         @(negedge mclk);
         w++;
      end
      repeat (bit_cycles / 2) @(negedge mclk);
      for (int i = 0; i < n; i++) begin
         fr[i] = line_in;
         if (i < n - 1) repeat (bit_cycles) @(negedge mclk);
      end
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: register and line tests of the serial transceiver pair
// Assumes: divisor 1 gives sixteen mclk cycles per bit
// Notes: waitrequest copied mid-cycle so the bus tasks never race
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic special_mode = 1'b0;
   logic wait_mode = 1'b0;
   logic clock_synth_supply = 1'b1;
   logic [1:0] gpio_tx = 2'b00;
   logic [1:0] tx_dir = 2'b00;
   logic [3:0] be = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] pin_tx_out, pin_tx_oe_n, pin_rx_out, pin_rx_oe_n, rx_wake_irq;
   wire logic [1:0] tx_line;
   wire logic [1:0] rx_line;
   logic far_line;
   logic ws_d;
   logic odd_level;
   logic [7:0] b, cfg;
   logic [8:0] d;
   logic [10:0] fr, e;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int nd, w;
   // pull-ups on both pins, far end wired onto channel 0 receive pin
   assign tx_line = pin_tx_oe_n | pin_tx_out;
   assign rx_line = (pin_rx_oe_n | pin_rx_out) & {1'b1, far_line};
   asi_top i_dut (.mclk(mclk), .ce(1'b1), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(be), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .special_mode(special_mode), .wait_mode(wait_mode),
      .clock_synth_supply(clock_synth_supply), .tx_pin_direction_bit(tx_dir), .rx_pin_direction_bit(2'b00),
      .gpio_tx_out(gpio_tx), .gpio_rx_out(2'b00), .pin_tx_in(tx_line), .pin_tx_out(pin_tx_out),
      .pin_tx_oe_n(pin_tx_oe_n), .pin_rx_in(rx_line), .pin_rx_out(pin_rx_out), .pin_rx_oe_n(pin_rx_oe_n),
      .rx_wake_irq(rx_wake_irq));
   asi_remote i_far (.mclk(mclk), .line_in(tx_line[0]), .line_out(far_line));
   // clock, and a hang limit well above the expected run
   always #2.5 mclk = ~mclk;
   always @(negedge mclk) ws_d = avs_waitrequest;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge
   task automatic wait_ack;
      do @(posedge mclk); while (ws_d !== 1'b0);
   endtask
   // each access starts just after a rising edge, whatever the caller waited on
   task automatic bus_wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h000000, v};
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic bus_rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      v = avs_readdata[7:0];
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] v;
      bus_rd(a, v);
      chk(v, exp);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk(pin_tx_oe_n, 2'b11);
      // general purpose drive on both transmit pins, channel 0 open drain
      tx_dir <= 2'b11;
      gpio_tx <= 2'b01;
      bus_wr(6'h08, 8'h40);
      repeat (2) @(negedge mclk);
      chk({pin_tx_oe_n, pin_tx_out}, 4'b0101);
      bus_wr(6'h08, 8'h00);
      tx_dir <= 2'b00;
      rd_chk(6'h10, 8'hC0);
      rd_chk(6'h08, 8'h00);
      rd_chk(6'h00, 8'h00);
      bus_wr(6'h00, 8'hFF);
      rd_chk(6'h00, 8'h1F);
      special_mode <= 1'b1;
      bus_wr(6'h00, 8'hE0);
      rd_chk(6'h00, 8'hE0);
      special_mode <= 1'b0;
      bus_wr(6'h00, 8'h00);
      bus_wr(6'h28, 8'h13);
      rd_chk(6'h08, 8'h00);
      rd_chk(6'h28, 8'h13);
      // a write without its low byte lane is ignored
      be <= 4'hE;
      bus_wr(6'h28, 8'hFF);
      rd_chk(6'h28, 8'h13);
      be <= 4'hF;
      $display("test registers done");
      // divisor zero keeps the line quiet until the low byte arrives
      bus_wr(6'h0C, 8'h0C);
      bus_rd(6'h10, b);
      bus_wr(6'h1C, 8'h55);
      odd_level = 1'b0;
      repeat (400) @(negedge mclk) odd_level |= (tx_line[0] !== 1'b1);
      chk(odd_level, 1'b0);
      bus_wr(6'h04, 8'h01);
      i_far.catch_frame(10, fr);
      chk(fr, {2'b11, 8'h55, 1'b0});
      $display("test baud start done");
      // five formats: 8-bit with no, even and odd parity, 9-bit with no and odd parity
      for (int k = 0; k < 5; k++) begin
         cfg = (k < 3) ? 8'h00 | (k == 0 ? 8'h00 : (k == 1 ? 8'h02 : 8'h03)) : (k == 3 ? 8'h10 : 8'h13);
         nd = cfg[4] ? 9 : 8;
         d = {1'b1, 8'hA6 ^ k[7:0]};
         if (cfg[1]) begin
            d[nd - 1] = cfg[0];
            for (int j = 0; j < nd - 1; j++) d[nd - 1] ^= d[j];
         end
         e = 11'h7FF;
         e[0] = 1'b0;
         for (int j = 0; j < nd; j++) e[j + 1] = d[j];
         bus_wr(6'h08, cfg);
         bus_rd(6'h10, b);
         bus_wr(6'h18, 8'h40);
         bus_wr(6'h1C, d[7:0]);
         i_far.catch_frame(nd + 2, fr);
         chk(fr, e);
      end
      $display("test transmit formats done");
      // receive with even parity, good then bad, wake request meanwhile
      bus_wr(6'h08, 8'h02);
      bus_wr(6'h0C, 8'h2C);
      wait_mode <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         fork
            i_far.send({2'b11, (k == 1) ? 8'hDA : 8'h5A, 1'b0}, 10);
            begin
               repeat (40) @(posedge mclk);
               chk(rx_wake_irq, 2'b01);
               clock_synth_supply <= 1'b0;
               repeat (10) @(posedge mclk);
               chk(rx_wake_irq, 2'b00);
               clock_synth_supply <= 1'b1;
            end
         join
         repeat (8) @(posedge mclk);
         rd_chk(6'h10, {7'b1110000, k[0]});
         bus_rd(6'h1C, b);
         chk(b[6:0], 7'h5A);
         rd_chk(6'h10, 8'hC0);
      end
      wait_mode <= 1'b0;
      $display("test receive done");
      // internal loop with the receive pin held low by the far end
      bus_wr(6'h0C, 8'h0C);
      bus_wr(6'h08, 8'h80);
      i_far.hold(1'b0);
      repeat (4) @(posedge mclk);
      chk({pin_tx_oe_n[0], pin_tx_out[0]}, 2'b01);
      bus_rd(6'h10, b);
      bus_wr(6'h1C, 8'h3C);
      w = 0;
      b = 8'h00;
      while (b[5] !== 1'b1 && w < 100) begin
         bus_rd(6'h10, b);
         w++;
      end
      rd_chk(6'h1C, 8'h3C);
      // single wire: pin driven as output and read back through it
      tx_dir <= 2'b01;
      bus_wr(6'h08, 8'hA0);
      bus_rd(6'h10, b);
      bus_wr(6'h1C, 8'h96);
      i_far.catch_frame(10, fr);
      chk(fr, {2'b11, 8'h96, 1'b0});
      repeat (40) @(posedge mclk);
      rd_chk(6'h1C, 8'h96);
      tx_dir <= 2'b00;
      bus_wr(6'h08, 8'hC0);
      repeat (4) @(posedge mclk);
      chk(pin_tx_oe_n[0], 1'b1);
      i_far.hold(1'b1);
      $display("test loop done");
      // break holds the line low across nearly two whole frames
      bus_wr(6'h08, 8'h00);
      bus_wr(6'h0C, 8'h09);
      w = 0;
      while (tx_line[0] !== 1'b0 && w < 400) begin
         @(negedge mclk);
         w++;
      end
      odd_level = 1'b0;
      repeat (315) @(negedge mclk) odd_level |= (tx_line[0] !== 1'b0);
      chk(odd_level, 1'b0);
      bus_wr(6'h0C, 8'h08);
      $display("test break done");
      give_verdict();
   end
endmodule
`default_nettype wire
